// file: inc/eipd_pkg.sv
// Constants, register layout and carrier types of the external pin interrupt detector.
// Assumes a 32-bit APB slave and pins that are synchronous to pclk.
package eipd_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFS_SENSE = 12'h000;
	localparam logic [11:0] OFS_IRQ_EN = 12'h004;
	localparam logic [11:0] OFS_GLOBAL = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [11:0] OFS_CLEAR = 12'h010;
	localparam logic [11:0] OFS_MASK0 = 12'h014;
	localparam logic [11:0] OFS_MASK1 = 12'h018;
	localparam logic [11:0] OFS_MASK2 = 12'h01c;
	localparam logic [11:0] OFS_PINS = 12'h020;

	// ==========================================================
	// Reset values
	localparam logic [3:0] SENSE_RESET = 4'h0;
	localparam logic [4:0] SRC_RESET = 5'h00;
	localparam logic GLOBAL_RESET = 1'b0;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [6:0] MASK1_RESET = 7'h00;
	localparam logic PIN_RESET = 1'b1;

	// ==========================================================
	// Field positions
	localparam int STAT_EXT_LSB = 0;
	localparam int STAT_PC_LSB = 2;
	localparam int PINS_EXT_LSB = 24;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SENSE_LOW = 2'h0,
		SENSE_ANY = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} eipd_sense_t;

	typedef struct packed {
		eipd_sense_t sense1;
		eipd_sense_t sense0;
	} eipd_sense_ctl_t;

	typedef struct packed {
		logic [2:0] pc;
		logic [1:0] ext;
	} eipd_src_t;

	typedef struct packed {
		eipd_sense_ctl_t sense;
		eipd_src_t irq_en;
		logic global_en;
		logic [7:0] mask2;
		logic [6:0] mask1;
		logic [7:0] mask0;
	} eipd_regs_t;

	typedef enum logic [8:0] {
		SEL_NONE = 9'h000,
		SEL_SENSE = 9'h001,
		SEL_IRQ_EN = 9'h002,
		SEL_GLOBAL = 9'h004,
		SEL_STATUS = 9'h008,
		SEL_CLEAR = 9'h010,
		SEL_MASK0 = 9'h020,
		SEL_MASK1 = 9'h040,
		SEL_MASK2 = 9'h080,
		SEL_PINS = 9'h100
	} eipd_sel_t;

	function automatic eipd_sel_t eipd_decode(input logic [11:0] addr);
		eipd_sel_t sel;
		sel = SEL_NONE;
		case (addr)
			OFS_SENSE: sel = SEL_SENSE;
			OFS_IRQ_EN: sel = SEL_IRQ_EN;
			OFS_GLOBAL: sel = SEL_GLOBAL;
			OFS_STATUS: sel = SEL_STATUS;
			OFS_CLEAR: sel = SEL_CLEAR;
			OFS_MASK0: sel = SEL_MASK0;
			OFS_MASK1: sel = SEL_MASK1;
			OFS_MASK2: sel = SEL_MASK2;
			OFS_PINS: sel = SEL_PINS;
			default: sel = SEL_NONE;
		endcase
		return sel;
	endfunction

endpackage

// file: src/eipd_sense_unit.sv
// Sense logic for one dedicated interrupt pin: sampling, edge and level detection.
// Assumes the pin is synchronous to pclk; the low-level path is purely combinational.
`timescale 1ns/1ps
module eipd_sense_unit
	import eipd_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin and mode
	input wire logic pin,
	input wire eipd_sense_t mode,
	// Detection
	output logic sample,
	output logic hit,
	output logic level_low
);

	logic prev;
	logic [1:0] valid;
	logic next_sample;
	logic next_prev;
	logic [1:0] next_valid;

	// ==========================================================
	// Sampling
	always_comb
	begin
		next_sample = pin;
		next_prev = sample;
		next_valid = {valid[0], 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sample <= PIN_RESET;
			prev <= PIN_RESET;
			valid <= 2'h0;
		end
		else
		begin
			sample <= next_sample;
			prev <= next_prev;
			valid <= next_valid;
		end
	end

	// ==========================================================
	// Detection
	// No edge is reported until two real samples exist, so reset is no edge
	always_comb
	begin
		hit = 1'b0;
		if (valid[1])
		begin
			case (mode)
				SENSE_ANY: hit = sample ^ prev; // RL17 RL12 RL6
				SENSE_FALL: hit = prev & ~sample; // RL17 RL12 RL6
				SENSE_RISE: hit = ~prev & sample; // RL17 RL12 RL6
				default: hit = 1'b0;
			endcase
		end
	end

	// Asynchronous, so it still works while the clock is stopped
	assign level_low = (mode == SENSE_LOW) & ~pin; // RL7

	a_rise_hit: assert property (@(posedge pclk) disable iff (!presetn) // RL12
		(mode == SENSE_RISE) && valid[0] && !sample && pin ##1 (mode == SENSE_RISE) |-> hit)
		else $error("rising edge missed");

	a_level_no_edge: assert property (@(posedge pclk) disable iff (!presetn) // RL16
		(mode == SENSE_LOW) |-> !hit)
		else $error("edge reported in level mode");

endmodule

// file: src/eipd_top.sv
// External pin interrupt detector: two dedicated sense pins, 24 pin-change inputs
// in three masked banks, flags, enables and an APB register slave.
// Assumes pins are synchronous to pclk and a zero-wait APB master.
//
// Notes on behaviour
// [RL1] Enabled interrupts fire even when the pin is driven as an output.
// [RL2] Bank 2 change raises request 2, bank 1 request 1, bank 0 request 0.
// [RL3] Per-bank masks choose contributing pins; masked pins are ignored.
// [RL4] Pin-change detection works without the clock, to wake from deep sleep.
// [RL5] Level mode requests the interrupt for as long as the pin stays low.
// [RL6] Edge detection on dedicated pins is clocked, so stopped clock misses edges.
// [RL7] Low-level detection is asynchronous so it can wake from deep sleep.
// [RL8] Level ending before start-up completes wakes the device but gives no interrupt.
// [RL9] Pin one sense select at bits 3:2: low, change, falling, rising.
// [RL10] Pin zero sense select at bits 1:0, same encoding.
// [RL11] Dedicated interrupt reaches CPU only with global enable and its own enable.
// [RL12] Pin sampled before edge detection; pulses over one clock always detected.
// [RL13] Source must hold level low until current instruction completes.
// [RL14] Sense control bits 7:4 ignore writes and read zero.
// [RL15] Trigger sets the flag; vector execution or writing one clears it.
// [RL16] Flag of a level-sensed pin is held cleared.
// [RL17] Edges found by comparing current sample with previous clock's sample.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module eipd_top
	import eipd_pkg::*;
(
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins, read at the pad whatever their direction
	input wire logic ext_irq_pin_zero,
	input wire logic ext_irq_pin_one,
	input wire logic [23:0] pin_change_inputs,
	// CPU side
	input wire logic [4:0] vec_ack,
	output logic [1:0] ext_req,
	output logic pin_change_req_bank0,
	output logic pin_change_req_bank1,
	output logic pin_change_req_bank2,
	output logic irq,
	output logic wake
);

	eipd_regs_t regs;
	eipd_regs_t next_regs;
	eipd_src_t status;
	eipd_src_t next_status;
	logic [31:0] next_prdata;
	logic [23:0] pc_samp;
	logic [23:0] pc_prev;
	logic [1:0] pc_valid;
	logic [23:0] next_pc_samp;
	logic [23:0] next_pc_prev;
	logic [1:0] next_pc_valid;
	logic [1:0] ext_samp;
	logic [1:0] ext_hit;
	logic [1:0] ext_level;
	logic [1:0] ext_pin;
	eipd_sense_t ext_mode [2];
	logic [23:0] pc_mask;
	logic [23:0] pc_change;
	logic [23:0] pc_async;
	logic [2:0] pc_hit;
	logic [2:0] pc_async_bank;
	eipd_sel_t wsel;
	eipd_sel_t rsel;
	logic wr_en;
	logic setup;
	eipd_src_t clr;
	eipd_src_t set;
	eipd_src_t gated;

	// ==========================================================
	// APB handshake
	// Zero wait states; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign setup = psel & ~penable;
	assign wsel = eipd_decode(paddr);
	assign rsel = eipd_decode(paddr);
	assign wr_en = psel & penable & pwrite;
	assign pslverr = psel & penable & (wsel == SEL_NONE);

	// ==========================================================
	// Dedicated pins
	assign ext_pin = {ext_irq_pin_one, ext_irq_pin_zero}; // RL1
	assign ext_mode[0] = regs.sense.sense0; // RL10
	assign ext_mode[1] = regs.sense.sense1; // RL9

	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_sense
			eipd_sense_unit u_sense (
				.pclk(pclk),
				.presetn(presetn),
				.pin(ext_pin[i]),
				.mode(ext_mode[i]),
				.sample(ext_samp[i]),
				.hit(ext_hit[i]),
				.level_low(ext_level[i])
			);
		end
	endgenerate

	// ==========================================================
	// Pin-change banks
	// Bank 1 has seven pins; input 15 has no mask bit and never counts
	assign pc_mask = {regs.mask2, 1'b0, regs.mask1, regs.mask0}; // RL3
	assign pc_change = (pc_samp ^ pc_prev) & pc_mask & {24{pc_valid[1]}}; // RL3
	assign pc_async = (pin_change_inputs ^ pc_samp) & pc_mask & {24{pc_valid[0]}}; // RL4

	generate
		for (genvar b = 0; b < 3; b++)
		begin : g_bank
			assign pc_hit[b] = |pc_change[b*8 +: 8]; // RL2
			assign pc_async_bank[b] = (|pc_async[b*8 +: 8]) & regs.irq_en.pc[b]; // RL4
		end
	endgenerate

	always_comb
	begin
		next_pc_samp = pin_change_inputs; // RL1
		next_pc_prev = pc_samp;
		next_pc_valid = {pc_valid[0], 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc_samp <= {24{PIN_RESET}};
			pc_prev <= {24{PIN_RESET}};
			pc_valid <= 2'h0;
		end
		else
		begin
			pc_samp <= next_pc_samp;
			pc_prev <= next_pc_prev;
			pc_valid <= next_pc_valid;
		end
	end

	// ==========================================================
	// Configuration registers
	always_comb
	begin
		next_regs = regs;
		if (wr_en)
		begin
			case (wsel)
				SEL_SENSE: next_regs.sense = pwdata[3:0]; // RL14 RL9 RL10
				SEL_IRQ_EN: next_regs.irq_en = pwdata[4:0];
				SEL_GLOBAL: next_regs.global_en = pwdata[0];
				SEL_MASK0: next_regs.mask0 = pwdata[7:0]; // RL3
				SEL_MASK1: next_regs.mask1 = pwdata[6:0]; // RL3
				SEL_MASK2: next_regs.mask2 = pwdata[7:0]; // RL3
				default: next_regs = regs;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			regs.sense <= SENSE_RESET;
			regs.irq_en <= SRC_RESET;
			regs.global_en <= GLOBAL_RESET;
			regs.mask2 <= MASK_RESET;
			regs.mask1 <= MASK1_RESET;
			regs.mask0 <= MASK_RESET;
		end
		else
		begin
			regs <= next_regs;
		end
	end

	// ==========================================================
	// Sticky flags
	// A trigger in the same cycle as a clear wins, so no event is lost
	always_comb
	begin
		clr = vec_ack; // RL15
		if (wr_en && (wsel == SEL_CLEAR))
		begin
			clr = clr | pwdata[4:0]; // RL15
		end
		set.ext = ext_hit; // RL15
		set.pc = pc_hit; // RL2
		next_status = (status & ~clr) | set;
		for (int i = 0; i < 2; i++)
		begin
			if (ext_mode[i] == SENSE_LOW)
			begin
				next_status.ext[i] = 1'b0; // RL16
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status <= SRC_RESET;
		end
		else
		begin
			status <= next_status;
		end
	end

	// ==========================================================
	// Requests to the CPU
	// Level requests follow the pin directly; a level gone before the clock
	// restarts leaves no flag, so the wake-up brings no interrupt
	always_comb
	begin
		gated = status & regs.irq_en & {5{regs.global_en}}; // RL11
		gated.ext = gated.ext | (ext_level & regs.irq_en.ext & {2{regs.global_en}}); // RL5 RL8
	end

	assign ext_req = gated.ext; // RL11
	assign pin_change_req_bank0 = gated.pc[0]; // RL2
	assign pin_change_req_bank1 = gated.pc[1]; // RL2
	assign pin_change_req_bank2 = gated.pc[2]; // RL2
	assign irq = |gated;
	// Wake needs no clock; it ignores the global enable like a real sleep exit
	assign wake = (|(ext_level & regs.irq_en.ext)) | (|pc_async_bank); // RL4 RL7

	// ==========================================================
	// Read data
	always_comb
	begin
		next_prdata = prdata;
		if (setup)
		begin
			next_prdata = 32'h0000_0000;
			case (rsel)
				SEL_SENSE: next_prdata[3:0] = regs.sense; // RL14
				SEL_IRQ_EN: next_prdata[4:0] = regs.irq_en;
				SEL_GLOBAL: next_prdata[0] = regs.global_en;
				SEL_STATUS: next_prdata[4:0] = status;
				SEL_MASK0: next_prdata[7:0] = regs.mask0;
				SEL_MASK1: next_prdata[6:0] = regs.mask1;
				SEL_MASK2: next_prdata[7:0] = regs.mask2;
				SEL_PINS: next_prdata[25:0] = {ext_samp, pc_samp};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else
		begin
			prdata <= next_prdata;
		end
	end

	// ==========================================================
	// Assertions
	a_sense_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL14
		psel && penable && !pwrite && (paddr == OFS_SENSE) |-> prdata[31:4] == 28'h0)
		else $error("sense control upper bits not zero");

	a_level_request: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		(regs.sense.sense0 == SENSE_LOW) && regs.irq_en.ext[0] && regs.global_en
		&& !ext_irq_pin_zero |-> ext_req[0])
		else $error("level request missing");

	a_level_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL16
		(regs.sense.sense1 == SENSE_LOW) && $stable(regs.sense) |-> !status.ext[1])
		else $error("level mode flag set");

	a_edge_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // RL15
		ext_hit[0] && (ext_mode[0] != SENSE_LOW) && !wr_en |=> status.ext[0])
		else $error("edge did not set flag");

	a_write_one_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL15
		wr_en && (paddr == OFS_CLEAR) && pwdata[2] && !pc_hit[0] |=> !status.pc[0])
		else $error("flag not cleared by write");

	a_masked_ignored: assert property (@(posedge pclk) disable iff (!presetn) // RL3
		!(|((pc_samp[15:8] ^ pc_prev[15:8]) & {1'b0, regs.mask1})) && !status.pc[1]
		|=> !status.pc[1])
		else $error("flag set by masked pin");

	a_bank2_toggle: assert property (@(posedge pclk) disable iff (!presetn) // RL2
		pc_valid[1] && (|((pc_samp[23:16] ^ pc_prev[23:16]) & regs.mask2)) |=> status.pc[2])
		else $error("bank 2 toggle missed");

	a_global_gate: assert property (@(posedge pclk) disable iff (!presetn) // RL11
		(ext_req != 2'h0) |-> regs.global_en && ((ext_req & ~regs.irq_en.ext) == 2'h0))
		else $error("request without enables");

	a_async_wake: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		pc_valid[0] && regs.irq_en.pc[0]
		&& (|((pin_change_inputs[7:0] ^ pc_samp[7:0]) & regs.mask0)) |-> wake)
		else $error("pin change wake missing");

	a_falling_flag: assert property (@(posedge pclk) disable iff (!presetn) // RL12
		(ext_mode[0] == SENSE_FALL) && ext_samp[0] && !ext_irq_pin_zero
		##1 (ext_mode[0] == SENSE_FALL) |=> status.ext[0])
		else $error("falling edge on pin zero not flagged");

	a_fall_detect: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		(ext_mode[1] == SENSE_FALL) && ext_samp[1] && !ext_irq_pin_one
		&& !wr_en && !vec_ack[1] && $stable(regs.sense) ##1 $stable(regs.sense)
		&& !wr_en && !vec_ack[1] |=> status.ext[1])
		else $error("falling edge not flagged");

	a_any_change: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		(ext_mode[1] == SENSE_ANY) && (ext_samp[1] != ext_irq_pin_one)
		##1 (ext_mode[1] == SENSE_ANY) |=> status.ext[1])
		else $error("pin one change not flagged");

	a_rise_flag: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		(ext_mode[1] == SENSE_RISE) && !ext_samp[1] && ext_irq_pin_one
		##1 (ext_mode[1] == SENSE_RISE) |=> status.ext[1])
		else $error("pin one rise not flagged");

	a_vector_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL15
		vec_ack[0] && !ext_hit[0] |=> !status.ext[0])
		else $error("flag not cleared by vector");

	a_level_wake: assert property (@(posedge pclk) disable iff (!presetn) // RL7
		(ext_mode[1] == SENSE_LOW) && regs.irq_en.ext[1] && !ext_irq_pin_one |-> wake)
		else $error("level wake missing");

	a_bank1_toggle: assert property (@(posedge pclk) disable iff (!presetn) // RL2
		pc_valid[1] && (|((pc_samp[14:8] ^ pc_prev[14:8]) & regs.mask1)) |=> status.pc[1])
		else $error("bank 1 toggle missed");

	a_bank0_request: assert property (@(posedge pclk) disable iff (!presetn) // RL2 RL11
		status.pc[0] && regs.irq_en.pc[0] && regs.global_en |-> pin_change_req_bank0 && irq)
		else $error("bank 0 request missing");

endmodule

// file: dv/eipd_pin_model.sv
// Off-chip drivers for the dedicated and pin-change interrupt pins.
// Assumes the bench calls drive() only after an earlier call has returned.
`timescale 1ns/1ps
module eipd_pin_model
(
	// Clock
	input wire logic pclk,
	// Pins
	output logic ext_irq_pin_zero,
	output logic ext_irq_pin_one,
	output logic [23:0] pin_change_inputs
);
	// ====
	// Driver
	initial
	begin
		ext_irq_pin_zero = 1'b1;
		ext_irq_pin_one = 1'b1;
		pin_change_inputs = 24'hffffff;
	end

	// Every level is held two edges, so no pulse is shorter than a clock
	task automatic drive(input logic a, input logic b, input logic [23:0] c);
		@(posedge pclk);
		ext_irq_pin_zero <= a;
		ext_irq_pin_one <= b;
		pin_change_inputs <= c;
		repeat (2) @(posedge pclk);
	endtask
endmodule

// file: dv/test_external_pin_interrupt_detector.sv
// Self-checking bench of the pin interrupt detector with an integer model.
// Assumes the zero-wait APB slave and two-edge flag latency of the design.
`timescale 1ns/1ps
module test_external_pin_interrupt_detector
	import eipd_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [4:0] vec_ack = 5'h00;
	logic [31:0] prdata;
	logic pready, pslverr, pin0, pin1, req0, req1, req2, irq, wake;
	logic [23:0] pcin;
	logic [1:0] ext_req;
	logic [31:0] rd;
	logic err;
	int n_fail = 0;
	int checks_done = 0;
	int seed = 45219;
	int exp_st = 0;
	int md0 = 0;
	int md1 = 0;
	int en = 0;
	int gl = 0;
	int m0 = 0;
	int m1 = 0;
	int m2 = 0;
	logic pe0 = 1'b1;
	logic pe1 = 1'b1;
	logic [23:0] ppc = 24'hffffff;
	logic [11:0] regs [7] = '{OFS_SENSE, OFS_IRQ_EN, OFS_GLOBAL, OFS_STATUS,
		OFS_MASK0, OFS_MASK1, OFS_MASK2};

	always #20 pclk = ~pclk;

	eipd_top u_eipd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
		.pin_change_inputs(pcin), .vec_ack(vec_ack), .ext_req(ext_req),
		.pin_change_req_bank0(req0), .pin_change_req_bank1(req1),
		.pin_change_req_bank2(req2), .irq(irq), .wake(wake));

	eipd_pin_model u_eipd_pin_model (.pclk(pclk), .ext_irq_pin_zero(pin0),
		.ext_irq_pin_one(pin1), .pin_change_inputs(pcin));

	// ====
	// Tasks
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic int hit(input int m, input logic o, input logic n);
		case (m)
			1: return int'(o != n);
			2: return int'(o && !n);
			3: return int'(!o && n);
			default: return 0;
		endcase
	endfunction

	task automatic set_sense(input int s1, input int s0);
		md0 = s0;
		md1 = s1;
		apb(1'b1, OFS_SENSE, 32'(s1 * 4 + s0));
		if (s0 == 0)
			exp_st &= ~1;
		if (s1 == 0)
			exp_st &= ~2;
	endtask

	task automatic clr(input int d);
		apb(1'b1, OFS_CLEAR, 32'(d));
		exp_st &= ~d;
	endtask

	task automatic pins(input logic a, input logic b, input logic [23:0] c);
		logic [23:0] d;
		logic k0, k1, k2;
		int w;
		d = ppc ^ c;
		k0 = |(d[7:0] & m0[7:0]);
		k1 = |(d[14:8] & m1[6:0]);
		k2 = |(d[23:16] & m2[7:0]);
		w = (k0 && en[2]) || (k1 && en[3]) || (k2 && en[4]) ||
			(md0 == 0 && !a && en[0]) || (md1 == 0 && !b && en[1]);
		fork
			u_eipd_pin_model.drive(a, b, c);
			begin
				@(posedge pclk);
				#1;
				check(wake, w);
			end
		join
		exp_st |= hit(md0, pe0, a) | (hit(md1, pe1, b) << 1) | ({k2, k1, k0} << 2);
		pe0 = a;
		pe1 = b;
		ppc = c;
	endtask

	task automatic cmp_all();
		int g;
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd, exp_st);
		g = gl ? (exp_st & en) : 0;
		if (gl && en[0] && md0 == 0 && !pe0)
			g |= 1;
		if (gl && en[1] && md1 == 0 && !pe1)
			g |= 2;
		check(32'({irq, req2, req1, req0, ext_req}), 32'({|g[4:0], g[4:0]}));
	endtask

	// ====
	// Sequence
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i])
		begin
			apb(1'b0, regs[i], 32'h0);
			check(rd, 32'h0);
		end
		apb(1'b1, 12'h024, 32'h1);
		check(err, 32'h1);
		apb(1'b0, 12'h024, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, OFS_SENSE, 32'hff);
		md0 = 3;
		md1 = 3;
		apb(1'b0, OFS_SENSE, 32'h0);
		check(rd, 32'h0f);
		check(err, 32'h0);
		en = 32'h1f;
		gl = 1;
		apb(1'b1, OFS_IRQ_EN, 32'h1f);
		apb(1'b1, OFS_GLOBAL, 32'h1);
		for (int m = 1; m < 4; m++)
		begin
			set_sense(m, m);
			clr(32'h1f);
			pins(1'b0, 1'b1, ppc);
			cmp_all();
			pins(1'b1, 1'b0, ppc);
			cmp_all();
			clr(32'h3);
			pins(1'b1, 1'b1, ppc);
			cmp_all();
		end
		set_sense(0, 0);
		cmp_all();
		pins(1'b0, 1'b1, ppc);
		cmp_all();
		pins(1'b1, 1'b0, ppc);
		cmp_all();
		pins(1'b1, 1'b1, ppc);
		cmp_all();
		apb(1'b1, OFS_GLOBAL, 32'h0);
		gl = 0;
		set_sense(3, 2);
		pins(1'b0, 1'b0, ppc);
		cmp_all();
		apb(1'b1, OFS_GLOBAL, 32'h1);
		gl = 1;
		cmp_all();
		@(posedge pclk);
		vec_ack <= 5'h01;
		@(posedge pclk);
		vec_ack <= 5'h00;
		exp_st &= ~1;
		cmp_all();
		set_sense(3, 3);
		pins(1'b1, 1'b1, ppc);
		repeat (8)
		begin
			m0 = $random(seed);
			m1 = $random(seed);
			m2 = $random(seed);
			apb(1'b1, OFS_MASK0, 32'(m0));
			apb(1'b1, OFS_MASK1, 32'(m1));
			apb(1'b1, OFS_MASK2, 32'(m2));
			m0 &= 32'hff;
			m1 &= 32'h7f;
			m2 &= 32'hff;
			apb(1'b0, OFS_MASK1, 32'h0);
			check(rd, m1);
			clr(32'h1f);
			pins(1'b1, 1'b1, 24'($random(seed)));
			cmp_all();
		end
		apb(1'b0, OFS_PINS, 32'h0);
		check(rd, {6'h00, pe1, pe0, ppc});
		close_out();
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		close_out();
	end
endmodule
